// *** design/tmo_defs.svh ***
/*
 * Register map, field positions and reset values of the 8-bit compare timer.
 * Assumes inclusion by bare name from the core module, the checker and the bench.
 */
`ifndef TMO_DEFS_SVH
`define TMO_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TMO_ADDR_W 8
`define TMO_OFF_STATUS 8'h00
`define TMO_OFF_COUNT 8'h04
`define TMO_OFF_CONST_A 8'h08
`define TMO_OFF_CONST_B 8'h0c
`define TMO_OFF_CTRL 8'h10
`define TMO_OFF_CCTRL 8'h14

// ----------------------------------------------------------------------
// Status / output control fields
// ----------------------------------------------------------------------
`define TMO_BIT_MATCH_B 7
`define TMO_BIT_MATCH_A 6
`define TMO_BIT_WRAP 5
`define TMO_BIT_FIXED 4
`define TMO_SEL_B_HI 3
`define TMO_SEL_B_LO 2
`define TMO_SEL_A_HI 1
`define TMO_SEL_A_LO 0

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define TMO_CLR_SEL_HI 1
`define TMO_CLR_SEL_LO 0
`define TMO_BIT_RUN 2
`define TMO_BIT_EXT_LEVEL 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TMO_OSEL_RST 4'h0
`define TMO_FLAGS_RST 3'h0
`define TMO_CLR_SEL_RST 2'h0
`define TMO_RUN_RST 1'h0
`define TMO_EXT_LEVEL_RST 1'h0
`define TMO_COUNT_RST 8'h00
`define TMO_CONST_RST 8'hff
`define TMO_PIN_RST 1'h0

`endif

// *** design/tmo_pkg.sv ***
/*
 * Types shared by the compare timer core and its match units.
 * Assumes the constants header sits next to it.
 */
package tmo_pkg;

    // Pin action taken on a compare match
    typedef enum logic [1:0] {
        TMO_ACT_KEEP = 2'h0,
        TMO_ACT_LOW = 2'h1,
        TMO_ACT_HIGH = 2'h2,
        TMO_ACT_TOGGLE = 2'h3
    } tmo_act_t;

    // Counter clear source
    typedef enum logic [1:0] {
        TMO_CLR_NONE = 2'h0,
        TMO_CLR_MATCH_A = 2'h1,
        TMO_CLR_MATCH_B = 2'h2,
        TMO_CLR_EXT = 2'h3
    } tmo_clr_t;

endpackage

// *** design/tmo_match_if.sv ***
/*
 * Bundle between the timer core and one compare match unit.
 * Assumes both ends share one clock domain.
 */
`timescale 1ns/1ps

interface tmo_match_if #(
    parameter int CNT_W = 8
);
    import tmo_pkg::*;

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] constant;
    logic tick;
    logic pin;
    tmo_act_t act;
    logic match;
    logic drive;
    logic level;

    modport unit (
        input count,
        input constant,
        input tick,
        input pin,
        input act,
        output match,
        output drive,
        output level
    );

    modport core (
        output count,
        output constant,
        output tick,
        output pin,
        output act,
        input match,
        input drive,
        input level
    );
endinterface

// *** design/tmo_match_unit.sv ***
/*
 * One compare channel: equality against a constant and the pin action.
 * Assumes the core supplies the count tick and the current pin level.
 */
`timescale 1ns/1ps

module tmo_match_unit import tmo_pkg::*; (
    tmo_match_if.unit mi
);

    // ----------------------------------------------------------------------
    // Match and pin action
    // ----------------------------------------------------------------------
    // Match only in the last state before the counter moves
    always_comb begin
        mi.match = mi.tick && (mi.count == mi.constant);
        mi.drive = 1'b0;
        mi.level = mi.pin;
        if (mi.match) begin
            case (mi.act)
                TMO_ACT_KEEP: begin
                    mi.drive = 1'b0;
                end
                TMO_ACT_LOW: begin
                    mi.drive = 1'b1;
                    mi.level = 1'b0;
                end
                TMO_ACT_HIGH: begin
                    mi.drive = 1'b1;
                    mi.level = 1'b1;
                end
                TMO_ACT_TOGGLE: begin
                    mi.drive = 1'b1;
                    mi.level = ~mi.pin;
                end
                default: begin
                    mi.drive = 1'b0;
                end
            endcase
        end
    end

endmodule

// *** design/tmo_timer.sv ***
/*
 * 8-bit compare timer channel: counter, two compare constants, status
 * flags with read-then-write-0 clearing, and the waveform output pin.
 * Assumes an APB master on ref_clk and pins synchronous to ref_clk.
 */
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`include "tmo_defs.svh"

module tmo_timer import tmo_pkg::*; #(
    parameter int CNT_W = 8
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`TMO_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_clear_in,
    input wire logic xfer_act_a,
    input wire logic xfer_act_b,
    input wire logic xfer_int_select_a,
    input wire logic xfer_int_select_b,
    output logic match_a_irq,
    output logic match_b_irq,
    output logic wave_out_pin,
    output logic wave_out_en
);

    // ----------------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------------
    // Status byte layout is fixed; counter must fit the data bus
    if (CNT_W != 8) begin : g_bad_width
        $error("tmo_timer: CNT_W must be 8");
    end

    // ----------------------------------------------------------------------
    // State
    // ----------------------------------------------------------------------
    logic [CNT_W-1:0] count_value_reg, count_value_next;
    logic [CNT_W-1:0] constant_a_reg, constant_a_next;
    logic [CNT_W-1:0] constant_b_reg, constant_b_next;
    logic [2:0] flags_reg, flags_next;
    logic [2:0] seen_reg, seen_next;
    logic [3:0] out_sel_reg, out_sel_next;
    logic [1:0] clear_sel_reg, clear_sel_next;
    logic run_reg, run_next;
    logic ext_clear_level_sel_reg, ext_clear_level_sel_next;
    logic ext_prev_reg, ext_prev_next;
    logic pin_reg, pin_next;
    logic ready_reg, ready_next;
    logic [31:0] prdata_reg, prdata_next;

    logic tick;
    logic hit;
    logic access;
    logic wr_fire;
    logic rd_fire;
    logic counter_clear;
    logic wrap;
    logic [7:0] status_view;
    logic [31:0] read_mux;
    tmo_clr_t clr_mode;

    tmo_match_if #(.CNT_W(CNT_W)) ma_if ();
    tmo_match_if #(.CNT_W(CNT_W)) mb_if ();

    // ----------------------------------------------------------------------
    // Compare units
    // ----------------------------------------------------------------------
    tmo_match_unit u_match_a (
        .mi(ma_if)
    );

    tmo_match_unit u_match_b (
        .mi(mb_if)
    );

    // Feed both units from the shared counter
    assign tick = ce && run_reg;
    assign ma_if.count = count_value_reg;
    assign ma_if.constant = constant_a_reg;
    assign ma_if.tick = tick;
    assign ma_if.pin = pin_reg;
    assign ma_if.act = tmo_act_t'(out_sel_reg[`TMO_SEL_A_HI:`TMO_SEL_A_LO]);
    assign mb_if.count = count_value_reg;
    assign mb_if.constant = constant_b_reg;
    assign mb_if.tick = tick;
    assign mb_if.pin = pin_reg;
    assign mb_if.act = tmo_act_t'(out_sel_reg[`TMO_SEL_B_HI:`TMO_SEL_B_LO]);

    // ----------------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------------
    // One wait state so read data always comes from a flop
    assign access = psel && penable;
    assign wr_fire = ce && access && ready_reg && pwrite;
    assign rd_fire = ce && access && ready_reg && !pwrite;
    assign hit = (paddr == `TMO_OFF_STATUS) || (paddr == `TMO_OFF_COUNT) ||
                 (paddr == `TMO_OFF_CONST_A) || (paddr == `TMO_OFF_CONST_B) ||
                 (paddr == `TMO_OFF_CTRL) || (paddr == `TMO_OFF_CCTRL);
    assign pready = ready_reg && ce;
    assign pslverr = ready_reg && ce && access && !hit;
    assign prdata = prdata_reg;

    always_comb begin
        status_view = {flags_reg, 1'b1, out_sel_reg};
    end

    // Read data selection
    always_comb begin
        read_mux = 32'h0000_0000;
        case (paddr)
            `TMO_OFF_STATUS: read_mux[7:0] = status_view;
            `TMO_OFF_COUNT: read_mux[CNT_W-1:0] = count_value_reg;
            `TMO_OFF_CONST_A: read_mux[CNT_W-1:0] = constant_a_reg;
            `TMO_OFF_CONST_B: read_mux[CNT_W-1:0] = constant_b_reg;
            `TMO_OFF_CTRL: read_mux[2:0] = {run_reg, clear_sel_reg};
            `TMO_OFF_CCTRL: read_mux[0] = ext_clear_level_sel_reg;
            default: read_mux = 32'h0000_0000;
        endcase
    end

    // Bus handshake next state
    always_comb begin
        ready_next = ready_reg;
        prdata_next = prdata_reg;
        if (ce) begin
            if (access && !ready_reg) begin
                ready_next = 1'b1;
                prdata_next = pwrite ? 32'h0000_0000 : read_mux;
            end else begin
                ready_next = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------------
    assign clr_mode = tmo_clr_t'(clear_sel_reg);
    // roll from all ones to zero
    assign wrap = tick && (count_value_reg == {CNT_W{1'b1}}) && !counter_clear;

    // Clear source decode
    always_comb begin
        counter_clear = 1'b0;
        case (clr_mode)
            TMO_CLR_NONE: counter_clear = 1'b0;
            TMO_CLR_MATCH_A: counter_clear = ma_if.match;
            TMO_CLR_MATCH_B: counter_clear = mb_if.match;
            TMO_CLR_EXT: begin
                if (ext_clear_level_sel_reg) begin
                    counter_clear = ce && ext_clear_in;
                end else begin
                    counter_clear = ce && ext_clear_in && !ext_prev_reg;
                end
            end
            default: counter_clear = 1'b0;
        endcase
    end

    // Count next state; clear beats a software load
    always_comb begin
        count_value_next = count_value_reg;
        ext_prev_next = ext_prev_reg;
        if (ce) begin
            ext_prev_next = ext_clear_in;
            if (counter_clear) begin
                count_value_next = '0;
            end else if (wr_fire && paddr == `TMO_OFF_COUNT) begin
                count_value_next = pwdata[CNT_W-1:0];
            end else if (tick) begin
                count_value_next = count_value_reg + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------------
    always_comb begin
        constant_a_next = constant_a_reg;
        constant_b_next = constant_b_reg;
        out_sel_next = out_sel_reg;
        clear_sel_next = clear_sel_reg;
        run_next = run_reg;
        ext_clear_level_sel_next = ext_clear_level_sel_reg;
        if (wr_fire) begin
            case (paddr)
                `TMO_OFF_STATUS: out_sel_next = pwdata[`TMO_SEL_B_HI:`TMO_SEL_A_LO];
                `TMO_OFF_CONST_A: constant_a_next = pwdata[CNT_W-1:0];
                `TMO_OFF_CONST_B: constant_b_next = pwdata[CNT_W-1:0];
                `TMO_OFF_CTRL: begin
                    clear_sel_next = pwdata[`TMO_CLR_SEL_HI:`TMO_CLR_SEL_LO];
                    run_next = pwdata[`TMO_BIT_RUN];
                end
                `TMO_OFF_CCTRL: ext_clear_level_sel_next = pwdata[`TMO_BIT_EXT_LEVEL];
                default: run_next = run_reg;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------------
    // Index 2 = match B, 1 = match A, 0 = wrap; a set always beats a clear
    always_comb begin
        logic [2:0] set_v;
        logic [2:0] clr_v;
        set_v = 3'h0;
        clr_v = 3'h0;
        flags_next = flags_reg;
        seen_next = seen_reg;
        if (ce) begin
            set_v[2] = mb_if.match;
            set_v[1] = ma_if.match;
            set_v[0] = wrap;
            if (rd_fire && paddr == `TMO_OFF_STATUS) begin
                seen_next = seen_reg | prdata_reg[`TMO_BIT_MATCH_B:`TMO_BIT_WRAP];
            end
            if (wr_fire && paddr == `TMO_OFF_STATUS) begin
                clr_v = seen_reg & ~pwdata[`TMO_BIT_MATCH_B:`TMO_BIT_WRAP];
                seen_next = 3'h0;
            end
            if (xfer_act_b && !xfer_int_select_b) begin
                clr_v[2] = 1'b1;
            end
            if (xfer_act_a && !xfer_int_select_a) begin
                clr_v[1] = 1'b1;
            end
            flags_next = (flags_reg & ~clr_v) | set_v;
        end
    end

    assign match_a_irq = flags_reg[1];
    assign match_b_irq = flags_reg[2];

    // ----------------------------------------------------------------------
    // Waveform output
    // ----------------------------------------------------------------------
    // A sets, B clears in pulse mode; A wins a tie
    // pulse train from clear on A
    always_comb begin
        pin_next = pin_reg;
        if (ce) begin
            if (ma_if.drive) begin
                pin_next = ma_if.level;
            end else if (mb_if.drive) begin
                pin_next = mb_if.level;
            end
        end
    end

    assign wave_out_pin = pin_reg;
    assign wave_out_en = |out_sel_reg;

    // ----------------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count_value_reg <= `TMO_COUNT_RST;
            constant_a_reg <= `TMO_CONST_RST;
            constant_b_reg <= `TMO_CONST_RST;
            flags_reg <= `TMO_FLAGS_RST;
            seen_reg <= `TMO_FLAGS_RST;
            out_sel_reg <= `TMO_OSEL_RST;
            clear_sel_reg <= `TMO_CLR_SEL_RST;
            run_reg <= `TMO_RUN_RST;
            ext_clear_level_sel_reg <= `TMO_EXT_LEVEL_RST;
            ext_prev_reg <= 1'b0;
            pin_reg <= `TMO_PIN_RST;
            ready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            count_value_reg <= count_value_next;
            constant_a_reg <= constant_a_next;
            constant_b_reg <= constant_b_next;
            flags_reg <= flags_next;
            seen_reg <= seen_next;
            out_sel_reg <= out_sel_next;
            clear_sel_reg <= clear_sel_next;
            run_reg <= run_next;
            ext_clear_level_sel_reg <= ext_clear_level_sel_next;
            ext_prev_reg <= ext_prev_next;
            pin_reg <= pin_next;
            ready_reg <= ready_next;
            prdata_reg <= prdata_next;
        end
    end

endmodule

// *** test/tmo_timer_sva.sv ***
/* Port-level assertions for the compare timer.
   Assumes the bind below attaches it to every timer instance. */
`timescale 1ns/1ps
`include "tmo_defs.svh"

module tmo_timer_sva (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic xfer_act_a,
    input wire logic xfer_act_b,
    input wire logic xfer_int_select_a,
    input wire logic xfer_int_select_b,
    input wire logic match_a_irq,
    input wire logic match_b_irq,
    input wire logic wave_out_pin,
    input wire logic wave_out_en
);
    logic done_w, rd_stat_w, clr_a_w, clr_b_w, seen_reg, seen_next;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // Completed transfers and the two legal flag-clearing causes
    assign done_w = psel & penable & pready;
    assign rd_stat_w = done_w & ~pwrite & (paddr == `TMO_OFF_STATUS);
    assign clr_a_w = (done_w & pwrite & (paddr == `TMO_OFF_STATUS) & ~pwdata[6])
        | (xfer_act_a & ~xfer_int_select_a);
    assign clr_b_w = (done_w & pwrite & (paddr == `TMO_OFF_STATUS) & ~pwdata[7])
        | (xfer_act_b & ~xfer_int_select_b);

    // Sticky: a flag was raised since reset, so the pin may have moved
    always_comb seen_next = seen_reg | match_a_irq | match_b_irq;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) seen_reg <= 1'b0;
        else seen_reg <= seen_next;
    end

    a_fixed_bit_one: assert property (rd_stat_w |-> prdata[4])
        else $error("status bit 4 read as 0");
    a_flag_a_cause: assert property ($fell(match_a_irq) |-> $past(clr_a_w))
        else $error("flag A dropped without a clearing cause");
    a_flag_b_cause: assert property ($fell(match_b_irq) |-> $past(clr_b_w))
        else $error("flag B dropped without a clearing cause");
    a_en_from_sel: assert property (rd_stat_w |-> wave_out_en == (prdata[3:0] != 4'h0))
        else $error("output enable disagrees with select bits");
    a_pin_low_reset: assert property (!seen_reg && !match_a_irq && !match_b_irq |-> !wave_out_pin)
        else $error("pin left low state before any match");
    a_pin_on_match: assert property ($changed(wave_out_pin) |-> match_a_irq || match_b_irq)
        else $error("pin moved without a match flag");
    a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("ready not after exactly one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    a_bad_addr: assert property (done_w && !pwrite && paddr > `TMO_OFF_CCTRL
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
endmodule

bind tmo_timer tmo_timer_sva tmo_timer_sva_i (.ref_clk, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .xfer_act_a, .xfer_act_b,
    .xfer_int_select_a, .xfer_int_select_b, .match_a_irq, .match_b_irq,
    .wave_out_pin, .wave_out_en);

// *** test/tmo_board_model.sv ***
/* Board side of the timer: clear trigger source and pulse meter.
   Assumes the pin and the clear line are synchronous to ref_clk. */
`timescale 1ns/1ps

module tmo_board_model (
    input wire logic ref_clk,
    input wire logic wave_out_pin,
    output logic ext_clear_in,
    output logic [7:0] width_reg,
    output logic [7:0] period_reg,
    output logic [7:0] delay_reg
);
    logic [7:0] hi_cnt, gap_cnt, dly_cnt;
    logic pin_q, armed;

    initial begin
        ext_clear_in = 1'b0;
        {width_reg, period_reg, delay_reg, hi_cnt, gap_cnt, dly_cnt} = '0;
        {pin_q, armed} = 2'b00;
    end

    // Meter: high width, rise-to-rise period, clear-release to rise delay
    always @(posedge ref_clk) begin
        pin_q <= wave_out_pin;
        hi_cnt <= wave_out_pin ? hi_cnt + 8'h1 : 8'h0;
        gap_cnt <= (wave_out_pin && !pin_q) ? 8'h1 : gap_cnt + 8'h1;
        if (wave_out_pin && !pin_q) period_reg <= gap_cnt;
        if (!wave_out_pin && pin_q) width_reg <= hi_cnt;
        if (armed) begin
            dly_cnt <= dly_cnt + 8'h1;
            if (wave_out_pin) begin
                delay_reg <= dly_cnt;
                armed <= 1'b0;
            end
        end
    end

    // Clear held high for n cycles, then delay measurement starts
    task automatic hold_clear(input int n);
        @(posedge ref_clk);
        ext_clear_in <= 1'b1;
        repeat (n) @(posedge ref_clk);
        ext_clear_in <= 1'b0;
        armed <= 1'b1;
        dly_cnt <= 8'h0;
    endtask
endmodule

// *** test/tmo_timer_tb.sv ***
/* Self-checking bench for the compare timer over APB.
   Assumes the timer, its checker and the board model are compiled first. */
`timescale 1ns/1ps
`include "tmo_defs.svh"

module tmo_timer_tb;
    logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, width_reg, period_reg, delay_reg;
    logic [31:0] pwdata, prdata, rd;
    logic ext_clear_in, match_a_irq, match_b_irq, wave_out_pin, wave_out_en;
    logic xfer_act_a, xfer_act_b, xfer_int_select_a, xfer_int_select_b;
    logic [3:0] sel_t [9] = '{4'h2, 4'h0, 4'h1, 4'h3, 4'h3, 4'h8, 4'h4, 4'hc, 4'hc};
    logic pin_t [9] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    int fails = 0, n_compared = 0, cyc = 0;

    tmo_timer tmo_timer_i (.ref_clk, .nrst, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ext_clear_in, .xfer_act_a, .xfer_act_b,
        .xfer_int_select_a, .xfer_int_select_b, .match_a_irq, .match_b_irq,
        .wave_out_pin, .wave_out_en);
    tmo_board_model tmo_board_model_i (.ref_clk, .wave_out_pin, .ext_clear_in,
        .width_reg, .period_reg, .delay_reg);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Transfer-controller service pulse on both channels
    task automatic xfer(input logic sa, input logic sb);
        @(posedge ref_clk);
        xfer_int_select_a <= sa;
        xfer_int_select_b <= sb;
        {xfer_act_a, xfer_act_b} <= 2'b11;
        @(posedge ref_clk);
        {xfer_act_a, xfer_act_b} <= 2'b00;
        @(posedge ref_clk);
    endtask

    initial begin
        {nrst, psel, penable, pwrite, xfer_act_a, xfer_act_b} = '0;
        {xfer_int_select_a, xfer_int_select_b} = 2'b11;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        rdx(`TMO_OFF_STATUS, 32'h10);
        chk(wave_out_pin, 1'b0);
        chk(wave_out_en, 1'b0);
        apb(1'b0, 8'h18, 32'h0);
        chk(err, 1'b1);
        wr(`TMO_OFF_STATUS, 32'hf0);
        rdx(`TMO_OFF_STATUS, 32'h10);
        $display("test reset_and_access done");
        // Clear on match A keeps the count at or below constant A
        wr(`TMO_OFF_CONST_A, 32'h3);
        wr(`TMO_OFF_CTRL, 32'h5);
        repeat (10) @(posedge ref_clk);
        wr(`TMO_OFF_CTRL, 32'h1);
        apb(1'b0, `TMO_OFF_COUNT, 32'h0);
        chk(rd <= 32'h3, 1'b1);
        wr(`TMO_OFF_STATUS, 32'h0);
        rdx(`TMO_OFF_STATUS, 32'h50);
        wr(`TMO_OFF_STATUS, 32'h0);
        rdx(`TMO_OFF_STATUS, 32'h10);
        $display("test match_a_clear done");
        // Run from 0xfe sets all three flags: match B at 0xff, the wrap, then match A at 3
        wr(`TMO_OFF_COUNT, 32'hfe);
        wr(`TMO_OFF_CTRL, 32'h4);
        repeat (8) @(posedge ref_clk);
        wr(`TMO_OFF_CTRL, 32'h0);
        rdx(`TMO_OFF_STATUS, 32'hf0);
        xfer(1'b1, 1'b1);
        chk({match_b_irq, match_a_irq}, 2'b11);
        xfer(1'b0, 1'b1);
        chk({match_b_irq, match_a_irq}, 2'b10);
        xfer(1'b1, 1'b0);
        chk({match_b_irq, match_a_irq}, 2'b00);
        rdx(`TMO_OFF_STATUS, 32'h30);
        wr(`TMO_OFF_STATUS, 32'h0);
        rdx(`TMO_OFF_STATUS, 32'h10);
        $display("test wrap_and_service done");
        // One A match at 3 and one B match at 5 per run
        wr(`TMO_OFF_CONST_B, 32'h5);
        for (int i = 0; i < 9; i++) begin
            wr(`TMO_OFF_COUNT, 32'h0);
            wr(`TMO_OFF_STATUS, {28'h0, sel_t[i]});
            wr(`TMO_OFF_CTRL, 32'h4);
            repeat (8) @(posedge ref_clk);
            wr(`TMO_OFF_CTRL, 32'h0);
            chk(wave_out_pin, pin_t[i]);
            chk(wave_out_en, sel_t[i] != 4'h0);
        end
        $display("test pin_actions done");
        // Delayed pulse after the external clear is released
        wr(`TMO_OFF_COUNT, 32'h0);
        wr(`TMO_OFF_CONST_A, 32'h4);
        wr(`TMO_OFF_CONST_B, 32'ha);
        wr(`TMO_OFF_STATUS, 32'h6);
        wr(`TMO_OFF_CCTRL, 32'h1);
        wr(`TMO_OFF_CTRL, 32'h7);
        tmo_board_model_i.hold_clear(5);
        repeat (20) @(posedge ref_clk);
        chk(delay_reg, 8'h5);
        chk(width_reg, 8'h6);
        $display("test delayed_pulse done");
        // Free-running pulse train, period A+1 and width B+1
        wr(`TMO_OFF_CONST_A, 32'h9);
        wr(`TMO_OFF_CONST_B, 32'h3);
        wr(`TMO_OFF_COUNT, 32'h0);
        wr(`TMO_OFF_CTRL, 32'h5);
        repeat (40) @(posedge ref_clk);
        chk(period_reg, 8'ha);
        chk(width_reg, 8'h4);
        $display("test pulse_train done");
        close_out();
    end
endmodule
